/* hw/ifr_engine.sv */
// Fragmentation and reassembly engine, transmit and receive paths
`timescale 1ns/1ps
module ifr_engine #(
  parameter int          OCT_W        = 12,
  parameter int          SLOTS        = 2,
  parameter int          BUF_DEPTH    = 4096,
  parameter int          TICK_CYCLES  = ifr_pkg::TICK_CYCLES,
  parameter logic [15:0] INACT_S      = 16'(ifr_pkg::INACT_DEFAULT_S)
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  // Transmit command
  input  wire logic             tx_start,
  input  wire logic [OCT_W-1:0] tx_len,
  input  wire logic [7:0]       tx_msg_id,
  input  wire logic             tx_ack_req,
  input  wire logic [3:0]       tx_max_hops,
  input  wire logic [3:0]       tx_num_dest,
  input  wire logic [OCT_W-1:0] max_link_transfer_unit,
  input  wire logic [OCT_W-1:0] hdr_len,
  // Transmit data from host
  input  wire logic [7:0]       tx_byte,
  output logic                  tx_byte_take,
  // Fragment stream to data link
  output logic                  frag_valid,
  output logic                  frag_first,
  output logic                  frag_last,
  output logic                  frag_is_hdr,
  output logic [7:0]            frag_byte,
  output logic [3:0]            frag_num,
  output logic [3:0]            frag_total,
  output logic [7:0]            frag_msg_id,
  output logic [3:0]            frag_hops,
  output logic                  tx_busy,
  output logic                  tx_error,
  // Fragment arrival from data link
  input  wire logic             rx_valid,
  input  wire logic [15:0]      rx_src,
  input  wire logic [7:0]       rx_msg_id,
  input  wire logic [3:0]       rx_frag_num,
  input  wire logic [3:0]       rx_frag_total,
  input  wire logic [OCT_W-1:0] rx_frag_size,
  input  wire logic             rx_ack_req,
  input  wire logic [OCT_W-1:0] rx_offset,
  input  wire logic [7:0]       rx_byte,
  input  wire logic             rx_byte_last,
  // Host side delivery
  output logic                  delivery_indication,
  output logic [15:0]           deliv_src,
  output logic [7:0]            deliv_msg_id,
  output logic [OCT_W-1:0]      deliv_len,
  output logic                  end_to_end_ack_trig,
  output logic                  slot_expired,
  output logic                  rx_drop
);
  localparam int SL_W = $clog2(SLOTS);
  localparam int TK_W = $clog2(TICK_CYCLES + 1);
  // Inactivity load capped at twice the longest acknowledgment period
  localparam logic [15:0] INACT_CAP  = 16'(ifr_pkg::INACT_FACTOR * ifr_pkg::ETE_MAX_S);
  localparam logic [15:0] INACT_LOAD = (INACT_S > INACT_CAP) ? INACT_CAP : INACT_S;
  // ------------------------------------------------------------
  // One-second prescaler
  // ------------------------------------------------------------
  logic [TK_W-1:0] tick_cnt;
  logic            tick;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (tick_cnt == TK_W'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick     <= 1'b0;
    end
  end
  // ------------------------------------------------------------
  // Transmit: fragment sizing
  // ------------------------------------------------------------
  logic [OCT_W-1:0] worst_hdr;
  logic [OCT_W-1:0] eff_hdr;
  logic [OCT_W-1:0] frag_data;
  logic [OCT_W:0]   need;
  // Worst case header: base plus one address entry per hop and destination
  assign worst_hdr = OCT_W'(ifr_pkg::HDR_BASE_OCT)
                   + OCT_W'(ifr_pkg::HDR_PER_ADDR) * (OCT_W'(tx_max_hops) + OCT_W'(tx_num_dest));
  assign eff_hdr   = tx_ack_req ? worst_hdr : hdr_len;
  assign frag_data = max_link_transfer_unit - eff_hdr;
  assign need      = {1'b0, eff_hdr} + {1'b0, tx_len};
  ifr_pkg::ifr_tx_e tx_st;
  logic [OCT_W-1:0] tx_rem;
  logic [OCT_W-1:0] tx_fsz;
  logic [OCT_W-1:0] tx_hsz;
  logic [OCT_W-1:0] tx_cnt;
  logic [OCT_W-1:0] tx_cur;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_st        <= ifr_pkg::IFR_TX_IDLE;
      tx_rem       <= '0;
      tx_fsz       <= '0;
      tx_hsz       <= '0;
      tx_cnt       <= '0;
      tx_cur       <= '0;
      frag_num     <= '0;
      frag_total   <= '0;
      frag_msg_id  <= '0;
      frag_hops    <= '0;
      tx_busy      <= 1'b0;
      tx_error     <= 1'b0;
    end else begin
      unique case (tx_st)
        ifr_pkg::IFR_TX_IDLE: begin
          tx_error <= 1'b0;
          if (tx_start) begin
            if (eff_hdr >= max_link_transfer_unit || tx_len == '0) begin
              tx_error <= 1'b1;
            end else begin
              // Split only when header plus data overflows the link unit
              tx_fsz <= (need > {1'b0, max_link_transfer_unit}) ? frag_data : tx_len;
              tx_hsz <= eff_hdr;
              frag_total <= 4'((32'(tx_len) + 32'(frag_data) - 1) / 32'(frag_data));
              if (32'(tx_len) > 32'(frag_data) * ifr_pkg::FRAG_MAX) begin
                tx_error <= 1'b1;
              end else begin
                tx_rem      <= tx_len;
                // Raised to the first position on the first header slot
                frag_num    <= 4'(ifr_pkg::FRAG_MIN - 1);
                frag_msg_id <= tx_msg_id;
                frag_hops   <= tx_max_hops;
                tx_cnt      <= '0;
                tx_busy     <= 1'b1;
                tx_st       <= ifr_pkg::IFR_TX_HDR;
              end
            end
          end
        end
        ifr_pkg::IFR_TX_HDR: begin
          // Same header on every fragment, only frag_num moves
          if (tx_cnt == '0) begin
            frag_num <= frag_num + 1'b1;
          end
          if (tx_cnt == tx_hsz - 1'b1) begin
            tx_cnt <= '0;
            tx_cur <= (tx_rem < tx_fsz) ? tx_rem : tx_fsz;
            tx_st  <= ifr_pkg::IFR_TX_DATA;
          end else begin
            tx_cnt <= tx_cnt + 1'b1;
          end
        end
        ifr_pkg::IFR_TX_DATA: begin
          tx_rem <= tx_rem - 1'b1;
          if (tx_cnt == tx_cur - 1'b1) begin
            tx_cnt <= '0;
            if (tx_rem == OCT_W'(1)) begin
              tx_busy <= 1'b0;
              tx_st   <= ifr_pkg::IFR_TX_IDLE;
            end else begin
              tx_st <= ifr_pkg::IFR_TX_HDR;
            end
          end else begin
            tx_cnt <= tx_cnt + 1'b1;
          end
        end
        default: tx_st <= ifr_pkg::IFR_TX_IDLE;
      endcase
    end
  end
  // Registered stream strobes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frag_valid   <= 1'b0;
      frag_first   <= 1'b0;
      frag_last    <= 1'b0;
      frag_is_hdr  <= 1'b0;
      frag_byte    <= '0;
      tx_byte_take <= 1'b0;
    end else begin
      frag_valid   <= (tx_st != ifr_pkg::IFR_TX_IDLE);
      frag_first   <= (tx_st == ifr_pkg::IFR_TX_HDR) && (tx_cnt == '0);
      frag_last    <= (tx_st == ifr_pkg::IFR_TX_DATA) && (tx_cnt == tx_cur - 1'b1);
      frag_is_hdr  <= (tx_st == ifr_pkg::IFR_TX_HDR);
      frag_byte    <= (tx_st == ifr_pkg::IFR_TX_DATA) ? tx_byte : 8'h00;
      tx_byte_take <= (tx_st == ifr_pkg::IFR_TX_DATA);
    end
  end
  // ------------------------------------------------------------
  // Receive: slot match and allocation
  // ------------------------------------------------------------
  logic [SLOTS-1:0]   s_busy;
  logic [15:0]        s_src   [SLOTS];
  logic [7:0]         s_id    [SLOTS];
  logic [3:0]         s_total [SLOTS];
  logic [15:0]        s_got   [SLOTS];
  logic [OCT_W-1:0]   s_len   [SLOTS];
  logic [SLOTS-1:0]   s_ack;
  logic [15:0]        s_timer [SLOTS];
  logic [7:0]         rx_buf  [SLOTS][BUF_DEPTH];
  logic               hit;
  logic               free_ok;
  logic [SL_W-1:0]    hit_idx;
  logic [SL_W-1:0]    free_idx;
  logic               dup;
  logic               bad;
  logic [SL_W-1:0]    cur;
  logic               use_ok;
  logic [OCT_W-1:0]   base;
  always_comb begin
    hit      = 1'b0;
    hit_idx  = '0;
    free_ok  = 1'b0;
    free_idx = '0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (s_busy[i] && s_src[i] == rx_src && s_id[i] == rx_msg_id && s_total[i] == rx_frag_total) begin
        hit     = 1'b1;
        hit_idx = SL_W'(i);
      end
      if (!s_busy[i]) begin
        free_ok  = 1'b1;
        free_idx = SL_W'(i);
      end
    end
  end
  assign bad    = rx_frag_num < 4'(ifr_pkg::FRAG_MIN) || rx_frag_num > rx_frag_total;
  assign cur    = hit ? hit_idx : free_idx;
  assign use_ok = !bad && (hit || free_ok);
  assign dup    = hit && s_got[hit_idx][rx_frag_num];
  // Offset from position and equal-size fragments
  assign base   = OCT_W'(32'(rx_frag_num - 4'd1) * 32'(rx_frag_size));
  // Fragment data written into the slot buffer
  always_ff @(posedge clk) begin
    if (rx_valid && use_ok && !dup && rx_offset < rx_frag_size) begin
      rx_buf[cur][OCT_W'(base + rx_offset)] <= rx_byte;
    end
  end
  // ------------------------------------------------------------
  // Receive: per-slot state, timers and completion
  // ------------------------------------------------------------
  logic [15:0] got_next;
  assign got_next = s_got[cur] | (16'h0001 << rx_frag_num);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_busy              <= '0;
      s_ack               <= '0;
      delivery_indication <= 1'b0;
      end_to_end_ack_trig <= 1'b0;
      slot_expired        <= 1'b0;
      rx_drop             <= 1'b0;
      deliv_src           <= '0;
      deliv_msg_id        <= '0;
      deliv_len           <= '0;
      for (int i = 0; i < SLOTS; i++) begin
        s_src[i]   <= '0;
        s_id[i]    <= '0;
        s_total[i] <= '0;
        s_got[i]   <= '0;
        s_len[i]   <= '0;
        s_timer[i] <= '0;
      end
    end else begin
      delivery_indication <= 1'b0;
      end_to_end_ack_trig <= 1'b0;
      slot_expired        <= 1'b0;
      rx_drop             <= 1'b0;
      // One independent inactivity timer per partial message
      for (int i = 0; i < SLOTS; i++) begin
        if (s_busy[i] && tick) begin
          if (s_timer[i] <= 16'd1) begin
            s_busy[i]    <= 1'b0;
            s_got[i]     <= '0;
            slot_expired <= 1'b1;
          end else begin
            s_timer[i] <= s_timer[i] - 1'b1;
          end
        end
      end
      if (rx_valid && rx_byte_last) begin
        if (!use_ok) begin
          rx_drop <= 1'b1;
        end else begin
          s_busy[cur]  <= 1'b1;
          s_src[cur]   <= rx_src;
          s_id[cur]    <= rx_msg_id;
          s_total[cur] <= rx_frag_total;
          s_timer[cur] <= INACT_LOAD;
          s_ack[cur]   <= rx_ack_req;
          if (dup) begin
            rx_drop <= 1'b1;
          end else begin
            s_got[cur] <= got_next;
            if (rx_frag_num == rx_frag_total) begin
              s_len[cur] <= base + rx_offset + 1'b1;
            end
            // Every position 1..total present
            if ((got_next >> 1) == ((16'h0001 << rx_frag_total) - 16'h0001)) begin
              s_busy[cur]         <= 1'b0;
              s_got[cur]          <= '0;
              delivery_indication <= 1'b1;
              end_to_end_ack_trig <= rx_ack_req | (hit & s_ack[cur]);
              deliv_src           <= rx_src;
              deliv_msg_id        <= rx_msg_id;
              deliv_len           <= (rx_frag_num == rx_frag_total) ? base + rx_offset + 1'b1 : s_len[cur];
            end
          end
        end
      end
    end
  end
endmodule

/* inc/ifr_pkg.sv */
// Constants and types for the intranet fragmentation and reassembly engine
// What this block does
// - Split a packet into fragments when header plus data exceeds the link unit.
// - Each fragment's data plus header never exceeds the link transfer unit.
// - Every fragment repeats the same header; only fragment position differs.
// - All fragments carry equal data, only the last may be shorter.
// - Fragment position gives each fragment's unique place within its message.
// - With acknowledgment, size fragments from worst-case header for the topology.
// - Worst-case header size is bounded by hop limit and destination count.
// - Combine a received fragment with earlier ones matching originator, ID, total.
// - Place fragment data at offset from position, assuming equal fragment lengths.
// - Reassembly completes whatever order the fragments arrive in.
// - A fragment arriving again before the rest is tolerated.
// - When the packet is rebuilt, raise a delivery indication upward.
// - If acknowledgment was requested, trigger it when the last fragment arrives.
// - Every fragment of a partial message restarts its inactivity timer.
// - Inactivity period defaults to twice the acknowledgment timer period.
// - One inactivity timer per partially rebuilt message.
// - On inactivity expiry, release all storage of that message.
// - Maximum hop count field holds the largest number of relays allowed.
// - Fragment position takes values 1 through 15.
// - Message identifier is an 8-bit value from 0 to 255.
// - Fixed part of the acknowledgment timer defaults to 20 seconds.
// - Acknowledgment timer never exceeds 600 seconds.
package ifr_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ          = 250_000_000;
  localparam int TICK_CYCLES     = CLK_HZ;
  localparam int ETE_FIXED_S     = 20;
  localparam int ETE_MAX_S       = 600;
  localparam int INACT_FACTOR    = 2;
  localparam int INACT_DEFAULT_S = INACT_FACTOR * ETE_FIXED_S;
  // ------------------------------------------------------------
  // Header fields
  // ------------------------------------------------------------
  localparam int FRAG_MIN        = 1;
  localparam int FRAG_MAX        = 15;
  localparam int HDR_BASE_OCT    = 9;
  localparam int HDR_PER_ADDR    = 2;
  localparam int RESET_ZERO      = 0;
  typedef enum logic [1:0] {
    IFR_TX_IDLE = 2'b00,
    IFR_TX_HDR  = 2'b01,
    IFR_TX_DATA = 2'b11
  } ifr_tx_e;
endpackage

/* testbench/ifr_engine_checker.sv */
// Concurrent assertions on the engine ports
`timescale 1ns/1ps
module ifr_engine_checker #(
  parameter int OCT_W = 12
) (
  input wire logic             clk,
  input wire logic             rstn,
  input wire logic             tx_start,
  input wire logic             tx_busy,
  input wire logic             tx_error,
  input wire logic             frag_valid,
  input wire logic             frag_first,
  input wire logic             frag_last,
  input wire logic             frag_is_hdr,
  input wire logic [3:0]       frag_num,
  input wire logic [3:0]       frag_total,
  input wire logic [7:0]       frag_msg_id,
  input wire logic [3:0]       frag_hops,
  input wire logic [OCT_W-1:0] max_link_transfer_unit,
  input wire logic             rx_valid,
  input wire logic             rx_byte_last,
  input wire logic             rx_ack_req,
  input wire logic             delivery_indication,
  input wire logic             end_to_end_ack_trig,
  input wire logic             rx_drop
);
  // ------------------------------------------------------------
  // Slot counters of the fragment being sent
  // ------------------------------------------------------------
  logic [15:0] seg;
  logic [15:0] dcnt;
  logic [15:0] dfirst;
  logic [3:0]  prev_num;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seg      <= 16'h0;
      dcnt     <= 16'h0;
      dfirst   <= 16'h0;
      prev_num <= 4'h0;
    end else if (frag_valid) begin
      seg  <= frag_first ? 16'h1 : seg + 16'h1;
      dcnt <= (frag_first ? 16'h0 : dcnt) + {15'h0, !frag_is_hdr};
      if (frag_last)
        prev_num <= frag_num;
      if (frag_last && frag_num == 4'h1)
        dfirst <= dcnt + 16'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_tx_answer: assert property (tx_start && !tx_busy |=> tx_error or (tx_busy ##1 frag_valid && frag_first))
    else $error("start not answered");
  a_err_cause: assert property (tx_error |-> $past(tx_start && !tx_busy))
    else $error("error without start");
  a_unit_fits: assert property (frag_valid && frag_last |-> seg + 16'h1 <= 16'(max_link_transfer_unit))
    else $error("fragment longer than link unit");
  a_same_header: assert property (frag_valid && (!frag_first || frag_num != 4'h1)
    |-> $stable(frag_msg_id) && $stable(frag_total) && $stable(frag_hops))
    else $error("header field changed in message");
  a_equal_data: assert property (frag_valid && frag_last && frag_num > 4'h1 |-> dcnt + 16'h1 == dfirst
    || (frag_num == frag_total && dcnt + 16'h1 <= dfirst))
    else $error("unequal fragment data");
  a_num_order: assert property (frag_valid && frag_first && frag_num != 4'h1 |-> frag_num == prev_num + 4'h1)
    else $error("fragment number out of sequence");
  a_num_range: assert property (frag_valid |-> frag_num >= 4'h1 && frag_num <= frag_total)
    else $error("fragment number out of range");
  a_deliv_cause: assert property (delivery_indication |-> $past(rx_valid && rx_byte_last) ##1 !delivery_indication)
    else $error("delivery without final octet");
  a_ack_cause: assert property (end_to_end_ack_trig |-> delivery_indication && $past(rx_ack_req))
    else $error("ack trigger without request");
  a_drop_cause: assert property (rx_drop |-> $past(rx_valid && rx_byte_last) && !delivery_indication)
    else $error("drop outside commit");
  c_deliver: cover property (end_to_end_ack_trig);
  c_drop: cover property (rx_drop);
  c_error: cover property (tx_error);
  c_multi: cover property (frag_valid && frag_first && frag_num == 4'h3);
endmodule
bind ifr_engine ifr_engine_checker #(.OCT_W(OCT_W)) u_ifr_engine_checker (.clk(clk), .rstn(rstn),
  .tx_start(tx_start), .tx_busy(tx_busy), .tx_error(tx_error), .frag_valid(frag_valid),
  .frag_first(frag_first), .frag_last(frag_last), .frag_is_hdr(frag_is_hdr), .frag_num(frag_num),
  .frag_total(frag_total), .frag_msg_id(frag_msg_id), .frag_hops(frag_hops),
  .max_link_transfer_unit(max_link_transfer_unit), .rx_valid(rx_valid), .rx_byte_last(rx_byte_last),
  .rx_ack_req(rx_ack_req), .delivery_indication(delivery_indication),
  .end_to_end_ack_trig(end_to_end_ack_trig), .rx_drop(rx_drop));

/* testbench/ifr_link_model.sv */
// Data link model that hands received fragments in octet by octet
`timescale 1ns/1ps
module ifr_link_model #(
  parameter int OCT_W = 12
) (
  input  wire logic             clk,
  output logic                  rx_valid,
  output logic [15:0]           rx_src,
  output logic [7:0]            rx_msg_id,
  output logic [3:0]            rx_frag_num,
  output logic [3:0]            rx_frag_total,
  output logic [OCT_W-1:0]      rx_frag_size,
  output logic                  rx_ack_req,
  output logic [OCT_W-1:0]      rx_offset,
  output logic [7:0]            rx_byte,
  output logic                  rx_byte_last
);
  initial begin
    {rx_valid, rx_src, rx_msg_id, rx_frag_num, rx_frag_total} = '0;
    {rx_frag_size, rx_ack_req, rx_offset, rx_byte, rx_byte_last} = '0;
  end
  task automatic send_frag(input logic [15:0] src, input logic [7:0] id, input logic [3:0] num,
                           input logic [3:0] tot, input int n, input logic ack);
    @(posedge clk);
    #1;
    rx_src = src;
    rx_msg_id = id;
    rx_frag_num = num;
    rx_frag_total = tot;
    rx_frag_size = 12'h004;
    rx_ack_req = ack;
    for (int i = 0; i < n; i++) begin
      rx_valid = 1'b1;
      rx_offset = OCT_W'(i);
      rx_byte = 8'(num * 16 + i);
      rx_byte_last = (i == n - 1);
      @(posedge clk);
      #1;
    end
    rx_valid = 1'b0;
    rx_byte_last = 1'b0;
    rx_byte = ~rx_byte;
    rx_msg_id = ~rx_msg_id;
  endtask
endmodule

/* testbench/intranet_fragment_reassembly_test.sv */
// Self-checking testbench for the fragmentation and reassembly engine
`timescale 1ns/1ps
module intranet_fragment_reassembly_test;
  localparam int OCT_W = 12;
  logic clk = 1'b0, rstn = 1'b0, tx_start = 1'b0, tx_ack_req = 1'b0;
  logic [OCT_W-1:0] tx_len = '0, max_link_transfer_unit = '0, hdr_len = '0, rx_frag_size, rx_offset, deliv_len;
  logic [7:0] tx_msg_id = 8'h00, tx_byte = 8'h00, frag_byte, frag_msg_id, rx_msg_id, rx_byte, deliv_msg_id;
  logic [3:0] tx_max_hops = 4'h0, tx_num_dest = 4'h0, frag_num, frag_total, frag_hops, rx_frag_num, rx_frag_total;
  logic tx_byte_take, frag_valid, frag_first, frag_last, frag_is_hdr, tx_busy, tx_error, rx_valid, rx_ack_req;
  logic rx_byte_last, delivery_indication, end_to_end_ack_trig, slot_expired, rx_drop;
  logic [15:0] rx_src, deliv_src, l_src, l_len;
  logic [7:0] exp_b, l_id;
  int err_total = 0, checks = 0, n_del = 0, n_ack = 0, n_drop = 0, n_exp = 0, hc, dc, exp_h, exp_n;
  int dsz[$];
  ifr_engine #(.OCT_W(OCT_W), .TICK_CYCLES(4), .INACT_S(16'h000a)) u_ifr_engine (.clk, .rstn, .tx_start, .tx_len,
    .tx_msg_id, .tx_ack_req, .tx_max_hops, .tx_num_dest, .max_link_transfer_unit, .hdr_len, .tx_byte,
    .tx_byte_take, .frag_valid, .frag_first, .frag_last, .frag_is_hdr, .frag_byte, .frag_num, .frag_total,
    .frag_msg_id, .frag_hops, .tx_busy, .tx_error, .rx_valid, .rx_src, .rx_msg_id, .rx_frag_num, .rx_frag_total,
    .rx_frag_size, .rx_ack_req, .rx_offset, .rx_byte, .rx_byte_last, .delivery_indication, .deliv_src,
    .deliv_msg_id, .deliv_len, .end_to_end_ack_trig, .slot_expired, .rx_drop);
  ifr_link_model #(.OCT_W(OCT_W)) u_ifr_link_model (.clk, .rx_valid, .rx_src, .rx_msg_id, .rx_frag_num,
    .rx_frag_total, .rx_frag_size, .rx_ack_req, .rx_offset, .rx_byte, .rx_byte_last);
  always #2 clk = ~clk;
  always @(posedge clk) tx_byte <= #1 tx_byte + 8'h01;
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // ------------------------------------------------------------
  // Monitor of the fragment stream and the receive pulses
  // ------------------------------------------------------------
  always @(posedge clk) begin
    check("byte_take", tx_byte_take, frag_valid && !frag_is_hdr);
    n_drop += (rx_drop === 1'b1);
    n_exp += (slot_expired === 1'b1);
    if (delivery_indication === 1'b1) begin
      n_del++;
      n_ack += (end_to_end_ack_trig === 1'b1);
      l_src = deliv_src;
      l_id = deliv_msg_id;
      l_len = 16'(deliv_len);
    end
    if (frag_valid === 1'b1) begin
      if (frag_first === 1'b1) begin
        hc = 0;
        dc = 0;
      end
      if (frag_is_hdr === 1'b1)
        hc++;
      else begin
        exp_b = tx_byte - 8'h01;
        check("frag_byte", frag_byte, exp_b);
        dc++;
      end
      if (frag_last === 1'b1) begin
        dsz.push_back(dc);
        check("hdr_slots", hc, exp_h);
        check("frag_num", frag_num, dsz.size());
        check("frag_total", frag_total, exp_n);
        check("frag_hops", frag_hops, tx_max_hops);
        check("frag_msg_id", frag_msg_id, tx_msg_id);
      end
    end
  end
  task automatic tx_run(input int len, unit, hdr, ack, hops, dest, eh, sz, nf, err);
    int k;
    @(posedge clk);
    #1;
    tx_len = OCT_W'(len);
    max_link_transfer_unit = OCT_W'(unit);
    hdr_len = OCT_W'(hdr);
    tx_ack_req = ack[0];
    tx_max_hops = 4'(hops);
    tx_num_dest = 4'(dest);
    tx_msg_id = tx_msg_id + 8'h01;
    {exp_h, exp_n, exp_b} = {eh, nf, tx_byte};
    dsz.delete();
    tx_start = 1'b1;
    cyc(1);
    tx_start = 1'b0;
    check("tx_error", tx_error, err);
    for (k = 0; k < 300 && tx_busy !== 1'b0; k++) cyc(1);
    cyc(3);
    check("tx_busy", tx_busy, 0);
    check("frag_count", dsz.size(), nf);
    foreach (dsz[i]) check("frag_data", dsz[i], (i == nf - 1) ? len - i * sz : sz);
  endtask
  initial begin
    cyc(6);
    rstn = 1'b1;
    tx_run(10, 8, 4, 0, 0, 0, 4, 4, 3, 0);
    tx_run(8, 17, 4, 1, 1, 1, 13, 4, 2, 0);
    tx_run(4, 8, 4, 0, 0, 0, 4, 4, 1, 0);
    tx_run(6, 8, 8, 0, 0, 0, 0, 0, 0, 1);
    u_ifr_link_model.send_frag(16'h0304, 8'h07, 4'h1, 4'h2, 4, 1'b0);
    u_ifr_link_model.send_frag(16'h0102, 8'h07, 4'h2, 4'h3, 4, 1'b1);
    u_ifr_link_model.send_frag(16'h0102, 8'h07, 4'h2, 4'h3, 4, 1'b1);
    cyc(2);
    check("drop_count", n_drop, 1);
    u_ifr_link_model.send_frag(16'h0102, 8'h07, 4'h3, 4'h3, 2, 1'b1);
    cyc(2);
    check("early_deliv", n_del, 0);
    u_ifr_link_model.send_frag(16'h0102, 8'h07, 4'h1, 4'h3, 4, 1'b1);
    cyc(2);
    check("deliv_count", n_del, 1);
    check("deliv_len", l_len, 16'h000a);
    check("deliv_src", l_src, 16'h0102);
    check("deliv_msg_id", l_id, 8'h07);
    check("ack_count", n_ack, 1);
    u_ifr_link_model.send_frag(16'h0304, 8'h07, 4'h2, 4'h2, 2, 1'b0);
    cyc(2);
    check("deliv_len", l_len, 16'h0006);
    check("ack_count", n_ack, 1);
    u_ifr_link_model.send_frag(16'h0506, 8'h09, 4'h1, 4'h2, 4, 1'b0);
    cyc(20);
    u_ifr_link_model.send_frag(16'h0506, 8'h09, 4'h1, 4'h2, 4, 1'b0);
    cyc(30);
    check("expired_early", n_exp, 0);
    cyc(20);
    check("expired", n_exp, 1);
    u_ifr_link_model.send_frag(16'h0506, 8'h09, 4'h2, 4'h2, 2, 1'b0);
    cyc(2);
    check("deliv_count", n_del, 2);
    wrap_up();
  end
  initial begin
    cyc(20000);
    err_total++;
    wrap_up();
  end
endmodule
